// File: hdl/rmp_unit.sv
// Region memory protection unit: region table and access checker.
// Assumes the core presents one access per cycle and reads the verdict
// one enabled cycle later; config ports are driven from the same clock.
module rmp_unit
(
    input  wire logic               clk,            // Core clock
    input  wire logic               reset,          // Async, active high
    input  wire logic               ce,             // Freezes all state low
    // Global options
    input  wire logic               unit_enable,    // Whole unit on
    input  wire logic               privileged_background_map,
    input  wire logic               check_in_fault_handlers,
    // Full region write
    input  wire logic               cfg_wr,         // One-cycle strobe
    input  wire logic [2:0]         cfg_region,
    input  wire logic [31:0]        cfg_base,
    input  wire logic [31:0]        cfg_attr,
    // Enable-only write
    input  wire logic               en_wr,          // One-cycle strobe
    input  wire logic [2:0]         en_region,
    input  wire logic               en_val,         // region_on / region_off
    // Readback
    input  wire logic [2:0]         rd_region,
    output logic      [31:0]        rd_base,
    output logic      [31:0]        rd_attr,
    output logic      [3:0]         region_count,
    // Access check
    input  wire logic               acc_valid,
    input  wire logic [31:0]        acc_addr,
    input  wire rmp_pkg::rmp_kind_t acc_kind,
    input  wire logic               acc_priv,       // Privileged mode
    input  wire logic               acc_in_fault,   // Hard fault or NMI
    output logic                    acc_done,       // Verdict strobe
    output logic                    acc_fault       // Memory management fault
);
    localparam int N = rmp_pkg::NUM_REGIONS;

    // Region table, one entry per slot
    logic [26:0] base_q [N];      // Base address from bit 5 up
    logic [4:0]  size_q [N];      // Size code as written
    logic [7:0]  sub_q  [N];      // subregion_off_bit per sub-region
    logic [2:0]  ap_q   [N];      // Permission code
    logic        xn_q   [N];      // Fetch forbidden
    logic        en_q   [N];      // region_on

    logic [N-1:0] hit;            // Regions matching this access
    logic [2:0]   win;            // Highest matching region
    logic         next_fault;     // Verdict before registering

    // Byte-size exponent; codes below the minimum act as 32 bytes
    function automatic logic [5:0] eff_bits(input logic [4:0] code);
        if (code < rmp_pkg::SIZE_CODE_MIN)
            return 6'h05;
        return {1'b0, code} + 6'h01;
    endfunction : eff_bits

    // Read/write permission for one access
    function automatic logic perm_ok(input logic [2:0] ap,
                                     input logic       priv,
                                     input logic       wr);
        case (ap)
            rmp_pkg::AP_RW_NONE: return priv;
            rmp_pkg::AP_RW_RO:   return priv || !wr;
            rmp_pkg::AP_RW_RW:   return 1'b1;
            rmp_pkg::AP_RO_NONE: return priv && !wr;
            rmp_pkg::AP_RO_RO:   return !wr;
            // No access and reserved codes both refuse
            default:             return 1'b0;
        endcase
    endfunction : perm_ok

    // Table writes; full write wins over enable-only write to same slot
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < N; i++)
            begin
                base_q[i] <= rmp_pkg::BASE_RESET;
                size_q[i] <= rmp_pkg::SIZE_RESET;
                sub_q[i]  <= rmp_pkg::SUB_RESET;
                ap_q[i]   <= rmp_pkg::AP_RESET;
                xn_q[i]   <= 1'b0;
                en_q[i]   <= 1'b0;
            end
        end
        else if (ce)
        begin
            if (cfg_wr)
            begin
                // Whole configuration, enable included, in one write
                base_q[cfg_region] <= cfg_base[31:rmp_pkg::BASE_LSB];
                size_q[cfg_region] <= cfg_attr[rmp_pkg::ATTR_SIZE_LSB +: 5];
                sub_q[cfg_region]  <= cfg_attr[rmp_pkg::ATTR_SUB_LSB +: 8];
                ap_q[cfg_region]   <= cfg_attr[rmp_pkg::ATTR_AP_LSB +: 3];
                xn_q[cfg_region]   <= cfg_attr[rmp_pkg::ATTR_XN_POS];
                en_q[cfg_region]   <= cfg_attr[rmp_pkg::ATTR_EN_POS];
            end
            // Enable-only write touches nothing else, so a region can
            // be switched off and on without reprogramming
            if (en_wr && !(cfg_wr && cfg_region == en_region))
                en_q[en_region] <= en_val;
        end
    end

    // Readback in the same layout as the write, unused bits zero
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            rd_base <= 32'h0000_0000;
            rd_attr <= 32'h0000_0000;
        end
        else if (ce)
        begin
            rd_base <= {base_q[rd_region], 5'h00};
            rd_attr <= {3'h0, xn_q[rd_region], 1'b0, ap_q[rd_region],
                        8'h00, sub_q[rd_region], 2'h0,
                        size_q[rd_region], en_q[rd_region]};
        end
    end

    // Count is fixed; programmed regions stay counted
    assign region_count = rmp_pkg::REGION_COUNT;

    // Region match, with sub-region holes for large regions
    always_comb
    begin
        logic [5:0]  nb;
        logic [32:0] diff;
        logic [2:0]  sub;
        nb   = 6'h05;
        diff = 33'h0_0000_0000;
        sub  = 3'h0;
        hit  = '0;
        for (int i = 0; i < N; i++)
        begin
            nb   = eff_bits(size_q[i]);
            diff = {1'b0, acc_addr ^ {base_q[i], 5'h00}};
            // Top three address bits inside the region pick the sub-region
            sub  = 3'(acc_addr >> (nb - 6'h03));
            hit[i] = en_q[i] && ((diff >> nb) == 33'h0_0000_0000)
                   && !(nb >= rmp_pkg::SUB_MIN_BITS
                        && sub_q[i][sub]);
        end
    end

    // Later slots override earlier ones
    always_comb
    begin
        win = 3'h0;
        for (int i = 0; i < N; i++)
            if (hit[i])
                win = 3'(i);
    end

    // Verdict for the current access
    always_comb
    begin
        next_fault = 1'b0;
        if (!unit_enable)
            next_fault = 1'b0;
        else if (acc_in_fault && !check_in_fault_handlers)
            next_fault = 1'b0;
        else if (|hit)
            next_fault = !perm_ok(ap_q[win], acc_priv,
                                  acc_kind == rmp_pkg::ACC_WRITE)
                       || (acc_kind == rmp_pkg::ACC_FETCH
                           && xn_q[win]);
        else
            // No match: only privileged code may fall back
            next_fault = !(acc_priv && privileged_background_map);
    end

    // Registered verdict, one enabled cycle after the request
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            acc_done  <= 1'b0;
            acc_fault <= 1'b0;
        end
        else if (ce)
        begin
            acc_done  <= acc_valid;
            acc_fault <= acc_valid && next_fault;
        end
    end

    chk_count_fixed: assert property (@(posedge clk) disable iff (reset)
        region_count == 4'h8)
        else $error("region count is not eight");

    chk_unit_off: assert property (@(posedge clk) disable iff (reset)
        ce && acc_valid && !unit_enable |=> acc_done && !acc_fault)
        else $error("fault raised while unit disabled");

    chk_handler_bypass: assert property (@(posedge clk) disable iff (reset)
        ce && acc_valid && acc_in_fault && !check_in_fault_handlers
        |=> !acc_fault)
        else $error("fault raised in unchecked handler");

    chk_no_match: assert property (@(posedge clk) disable iff (reset)
        ce && acc_valid && unit_enable && !acc_in_fault && hit == '0
        |=> acc_fault == !($past(acc_priv)
                           && $past(privileged_background_map)))
        else $error("unmatched access verdict wrong");

    chk_fetch_forbid: assert property (@(posedge clk) disable iff (reset)
        ce && acc_valid && unit_enable && !acc_in_fault && |hit
        && xn_q[win] && acc_kind == rmp_pkg::ACC_FETCH |=> acc_fault)
        else $error("fetch from forbidden region not faulted");

    chk_readback_attr: assert property (@(posedge clk) disable iff (reset)
        ce && cfg_wr && !en_wr && rd_region == cfg_region
        ##1 ce && $stable(rd_region)
        |=> rd_attr == ($past(cfg_attr, 2) & 32'h1700_FF3F))
        else $error("readback differs from written attributes");

    chk_disable_keeps: assert property (@(posedge clk) disable iff (reset)
        ce && en_wr && !cfg_wr
        |=> base_q[$past(en_region)] == $past(base_q[en_region])
            && ap_q[$past(en_region)] == $past(ap_q[en_region]))
        else $error("enable write changed region settings");

    chk_highest_wins: assert property (@(posedge clk) disable iff (reset)
        |hit |-> hit[win] && ((hit >> win) == 8'h01))
        else $error("winning region is not the highest match");
endmodule : rmp_unit

// File: hdl/rmp_pkg.sv
// Constants shared by the region memory protection unit.
// Assumes one core clock; all request ports come from logic on that clock.
package rmp_pkg;
    localparam int          NUM_REGIONS  = 8;            // Region slots
    localparam logic [3:0]  REGION_COUNT = 4'h8;          // Reported count
    // Attribute word layout
    localparam int          ATTR_EN_POS   = 0;            // region_on bit
    localparam int          ATTR_SIZE_LSB = 1;            // Size code, 5 bits
    localparam int          ATTR_SUB_LSB  = 8;            // Sub-region offs
    localparam int          ATTR_AP_LSB   = 24;           // Permission code
    localparam int          ATTR_XN_POS   = 28;           // execute_forbidden
    localparam int          BASE_LSB      = 5;            // Base kept above
    // Size code n means 2**(n+1) bytes
    localparam logic [4:0]  SIZE_CODE_MIN = 5'h04;        // 32 bytes
    localparam logic [4:0]  SIZE_CODE_MAX = 5'h1F;        // 4 gigabytes
    localparam logic [5:0]  SUB_MIN_BITS  = 6'h08;        // 256 bytes
    // Read/write permission codes, privileged/user
    localparam logic [2:0]  AP_NONE_NONE  = 3'h0;         // no_access_any_mode
    localparam logic [2:0]  AP_RW_NONE    = 3'h1;
    // priv_readwrite_user_readonly
    localparam logic [2:0]  AP_RW_RO      = 3'h2;
    localparam logic [2:0]  AP_RW_RW      = 3'h3;
    localparam logic [2:0]  AP_RO_NONE    = 3'h5;
    // priv_readonly_user_readonly
    localparam logic [2:0]  AP_RO_RO      = 3'h6;
    // Reset values
    localparam logic [26:0] BASE_RESET    = 27'h000_0000;
    localparam logic [4:0]  SIZE_RESET    = 5'h00;
    localparam logic [7:0]  SUB_RESET     = 8'h00;
    localparam logic [2:0]  AP_RESET      = 3'h0;
    // Kind of core access
    typedef enum logic [1:0] {ACC_FETCH, ACC_READ, ACC_WRITE} rmp_kind_t;
endpackage : rmp_pkg

// File: testbench/rmp_core_model.sv
// Behavioural model of the core load, store and fetch path.
// Assumes clk is the unit's core clock; the bench calls access().
module rmp_core_model
(
    input  wire logic          clk,          // Core clock
    output logic               acc_valid,    // Access this cycle
    output logic [31:0]        acc_addr,     // Access address
    output rmp_pkg::rmp_kind_t acc_kind,     // Fetch, read or write
    output logic               acc_priv,     // Privileged mode
    output logic               acc_in_fault, // Inside fault handler
    input  wire logic          acc_done,     // Verdict strobe
    input  wire logic          acc_fault     // Verdict
);
    timeunit 1ns;
    timeprecision 100ps;

    // Quiet bus at time zero
    initial
    begin
        acc_valid    = 1'b0;
        acc_addr     = 32'h0000_0000;
        acc_kind     = rmp_pkg::ACC_READ;
        acc_priv     = 1'b0;
        acc_in_fault = 1'b0;
    end

    // One access held for one cycle; the verdict is read a cycle later.
    // The released address is inverted so a stale value never passes.
    task automatic access(input logic [31:0] a, input rmp_pkg::rmp_kind_t k,
                          input logic p, input logic f,
                          output logic [1:0] v);
        @(negedge clk);
        acc_valid    = 1'b1;
        acc_addr     = a;
        acc_kind     = k;
        acc_priv     = p;
        acc_in_fault = f;
        @(negedge clk);
        v            = {acc_done, acc_fault};
        acc_valid    = 1'b0;
        acc_addr     = ~a;
    endtask : access
endmodule : rmp_core_model

// File: testbench/rmp_unit_tb.sv
// Self-checking bench for the region memory protection unit.
// Assumes one 100 MHz clock; inputs change on the falling edge.
module rmp_unit_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, reset, unit_enable, privileged_background_map;
    logic check_in_fault_handlers, cfg_wr, en_wr, en_val;
    logic [2:0] cfg_region, en_region, rd_region;
    logic [31:0] cfg_base, cfg_attr, rd_base, rd_attr, acc_addr;
    logic [3:0] region_count;
    logic acc_valid, acc_priv, acc_in_fault, acc_done, acc_fault;
    logic ce;    // Clock enable, lowered once to prove writes freeze
    rmp_pkg::rmp_kind_t acc_kind;
    int miscompares, samples_checked, cycles;
    // Permission codes and their allowed set {priv R, priv W, user R, W}
    localparam logic [2:0] AP[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    localparam logic [3:0] OK[6] = '{4'h0, 4'hC, 4'hE, 4'hF, 4'h8, 4'hA};
    localparam logic [31:0] R1B = 32'h2000_0000;

    always #5 clk = ~clk;

    rmp_unit i_dut (.clk(clk), .reset(reset), .ce(ce),
        .unit_enable(unit_enable),
        .privileged_background_map(privileged_background_map),
        .check_in_fault_handlers(check_in_fault_handlers),
        .cfg_wr(cfg_wr), .cfg_region(cfg_region), .cfg_base(cfg_base),
        .cfg_attr(cfg_attr), .en_wr(en_wr), .en_region(en_region),
        .en_val(en_val), .rd_region(rd_region), .rd_base(rd_base),
        .rd_attr(rd_attr), .region_count(region_count),
        .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_kind(acc_kind),
        .acc_priv(acc_priv), .acc_in_fault(acc_in_fault),
        .acc_done(acc_done), .acc_fault(acc_fault));
    rmp_core_model i_core (.clk(clk), .acc_valid(acc_valid),
        .acc_addr(acc_addr), .acc_kind(acc_kind), .acc_priv(acc_priv),
        .acc_in_fault(acc_in_fault), .acc_done(acc_done),
        .acc_fault(acc_fault));

    // Attribute word: enable, size code, sub-region offs, permission, XN
    function automatic logic [31:0] attr(input logic e, input logic [4:0] s,
        input logic [7:0] sub, input logic [2:0] ap, input logic xn);
        return {3'h0, xn, 1'b0, ap, 8'h00, sub, 2'h0, s, e};
    endfunction : attr

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h",
                     $time, got, exp);
        end
    endtask : chk

    task automatic cfg(input logic [2:0] r, input logic [31:0] b, a);
        @(negedge clk);
        {cfg_wr, cfg_region, cfg_base, cfg_attr} = {1'b1, r, b, a};
        // Point readback at the slot so the readback check sees the write
        rd_region = r;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg

    task automatic en(input logic [2:0] r, input logic v);
        @(negedge clk);
        {en_wr, en_region, en_val} = {1'b1, r, v};
        @(negedge clk);
        en_wr = 1'b0;
    endtask : en

    task automatic rdb(input logic [2:0] r, input logic [31:0] eb, ea);
        @(negedge clk);
        rd_region = r;
        @(negedge clk);
        chk(rd_base, eb);
        chk(rd_attr, ea);
    endtask : rdb

    // Verdict must arrive one cycle after the access, fault as expected
    task automatic acc(input logic [31:0] a, input rmp_pkg::rmp_kind_t k,
                       input logic p, f, ef);
        logic [1:0] v;
        i_core.access(a, k, p, f, v);
        chk({30'h0, v}, {30'h0, 1'b1, ef});
    endtask : acc

    task automatic final_report();
        if (miscompares == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            final_report();
        end
    end

    initial
    begin
        {clk, reset, unit_enable, privileged_background_map} = 4'b0100;
        {check_in_fault_handlers, cfg_wr, en_wr, en_val} = 4'h0;
        {cfg_region, en_region, rd_region} = 9'h000;
        {cfg_base, cfg_attr} = 64'h0;
        ce = 1'b1;
        {miscompares, samples_checked, cycles} = 0;
        repeat (5) @(posedge clk);
        @(negedge clk);
        reset = 1'b0;
        chk({28'h0, region_count}, 32'h0000_0008);
        rdb(3'h3, 32'h0000_0000, 32'h0000_0000);
        acc(R1B, rmp_pkg::ACC_WRITE, 1'b0, 1'b0, 1'b0);
        unit_enable = 1'b1;
        acc(R1B, rmp_pkg::ACC_READ, 1'b1, 1'b0, 1'b1);
        privileged_background_map = 1'b1;
        acc(R1B, rmp_pkg::ACC_READ, 1'b1, 1'b0, 1'b0);
        acc(R1B, rmp_pkg::ACC_READ, 1'b0, 1'b0, 1'b1);
        privileged_background_map = 1'b0;
        // Whole space open, then a 1 KB read-only, no-execute overlay
        cfg(3'h0, 32'h0, attr(1, 5'h1F, 8'h00, 3'h3, 0));
        cfg(3'h1, R1B, attr(1, 5'h09, 8'h04, 3'h6, 1));
        rdb(3'h1, R1B, attr(1, 5'h09, 8'h04, 3'h6, 1));
        acc(R1B + 16, rmp_pkg::ACC_WRITE, 1, 0, 1);
        acc(R1B + 16, rmp_pkg::ACC_READ, 0, 0, 0);
        acc(R1B + 16, rmp_pkg::ACC_FETCH, 1, 0, 1);
        acc(R1B + 'h110, rmp_pkg::ACC_WRITE, 1, 0, 0);
        acc(R1B + 'h190, rmp_pkg::ACC_WRITE, 1, 0, 1);
        en(3'h1, 1'b0);
        acc(R1B + 16, rmp_pkg::ACC_WRITE, 1, 0, 0);
        rdb(3'h1, R1B, attr(0, 5'h09, 8'h04, 3'h6, 1));
        en(3'h1, 1'b1);
        acc(R1B + 16, rmp_pkg::ACC_WRITE, 1, 0, 1);
        acc(R1B + 16, rmp_pkg::ACC_WRITE, 1, 1, 0);
        check_in_fault_handlers = 1'b1;
        acc(R1B + 16, rmp_pkg::ACC_WRITE, 1, 1, 1);
        // Every permission code; sub-region offs ignored on 32 bytes
        for (int i = 0; i < 6; i++)
        begin
            en(3'h2, 1'b0);
            cfg(3'h2, 32'h4000_0000,
                attr(1, 5'h04, 8'hFF, AP[i], 0));
            for (int j = 0; j < 4; j++)
                acc(32'h4000_001F,
                    j[0] ? rmp_pkg::ACC_WRITE : rmp_pkg::ACC_READ,
                    j < 2, 0, !OK[i][3 - j]);
        end
        // Region edges for each size code up to 1 GB
        for (int k = 4; k < 30; k++)
        begin
            en(3'h3, 1'b0);
            cfg(3'h3, 32'h8000_0000, attr(1, 5'(k), 8'h00, 3'h0, 0));
            acc(32'h8000_0000 + (32'h1 << (k + 1)) - 1,
                rmp_pkg::ACC_READ, 1, 0, 1);
            acc(32'h8000_0000 + (32'h1 << (k + 1)),
                rmp_pkg::ACC_READ, 1, 0, 0);
        end
        // Clock enable low: a region write in that time must not land,
        // so the no-access region below never appears
        ce = 1'b0;
        cfg(3'h4, 32'h6000_0000, attr(1, 5'h09, 8'h00, 3'h0, 0));
        ce = 1'b1;
        rdb(3'h4, 32'h0000_0000, 32'h0000_0000);
        acc(32'h6000_0000, rmp_pkg::ACC_READ, 1, 0, 0);
        final_report();
    end
endmodule : rmp_unit_tb
